/* File: rtl/internal_reset_pkg.sv */
// Constants and carrier types for the internal reset source block.
// Assumes an 8-bit register port and one system clock.
package internal_reset_pkg;

	localparam int unsigned CLK_HZ            = 50_000_000;
	localparam int unsigned ADDR_W            = 4;
	localparam int unsigned DATA_W            = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_SRC     = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_WDT_CTL = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_WDT_LIM = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_CAUSE   = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MSK = 4'h5;

	// reset_source_register fields
	localparam int unsigned BIT_SW_FORCE  = 4;
	localparam int unsigned BIT_WDT_FLAG  = 5;
	localparam int unsigned BIT_FLASH_ERR = 6;

	// Watchdog control fields
	localparam int unsigned BIT_WDT_EN    = 0;
	localparam int unsigned BIT_WDT_KICK  = 1;

	// Event bit positions in the interrupt status and mask registers
	localparam int unsigned EV_SW    = 0;
	localparam int unsigned EV_WDT   = 1;
	localparam int unsigned EV_FLASH = 2;
	localparam int unsigned EV_W     = 3;

	localparam logic [3:0]        WDT_DIV       = 4'hC;
	localparam logic [DATA_W-1:0] WDT_LIM_RESET = 8'hFF;
	localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
	localparam logic [EV_W-1:0]   ZERO_EV       = 3'h0;
	localparam int unsigned       RESET_HOLD    = 4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic              wr;
		logic              rd;
	} reg_req_type;

	// Illegal flash access reports from the flash access logic
	typedef struct packed {
		logic progBeyondLimit;
		logic codeReadBeyondLimit;
		logic fetchBeyondLimit;
		logic securityRefused;
		logic writeNoSupplyMonitor;
	} flash_fault_type;

	localparam int unsigned FAULT_W = $bits(flash_fault_type);

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} rst_state_type;

endpackage

/* File: rtl/internal_reset_sources.sv */
// Internal reset generator: watchdog, illegal flash access and software reset.
// Assumes fault strobes and the register port come from logic on mclk,
// and that sysResetN feeds the chip reset tree, not this block.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) After any reset the watchdog is enabled and ticks at the system clock divided by twelve.
// (R2) A watchdog expiry issues a system reset and sets the watchdog flag at bit five.
// (R3) Internal resets never drive or change the external reset pin.
// (R4) A programming write or erase above the user code limit causes a system reset.
// (R5) A code memory read instruction above the user code limit causes a system reset.
// (R6) An instruction fetch above the user code limit causes a system reset.
// (R7) A flash access refused by the security setting causes a system reset.
// (R8) A flash write or erase with the supply monitor disabled causes a system reset.
// (R9) A flash error reset sets the flash error flag at bit six.
// (R10) Writing one to bit four of the source register forces a system reset at once.
// (R11) After a software reset bit four reads back as one.
// (R12) The internal reset lasts at least one full cycle, releases on mclk, and flags survive it.
module internal_reset_sources
	import internal_reset_pkg::*;
#(
	parameter int unsigned          HOLD_CYCLES = RESET_HOLD,
	parameter logic [DATA_W-1:0]    LIMIT_RESET = WDT_LIM_RESET
) (
	input  wire logic               mclk,
	input  wire logic               rstn,
	input  wire reg_req_type        regReq,
	output logic [DATA_W-1:0]       regRdData,
	input  wire flash_fault_type    flashFault,
	output logic                    sysResetN,
	output logic                    rstPinOut,
	output logic                    rstPinOe,
	output logic                    irq
);

	if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : gHoldCheck
		$error("HOLD_CYCLES must lie in 1..255");
	end

	localparam logic [7:0] HOLD_LOAD = 8'(HOLD_CYCLES - 1);

	// Reset release is retimed so no flop sees rstn rise near an edge
	logic              rstnMeta_r;
	logic              rstnSync_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstnMeta_r <= 1'b0;
			rstnSync_r <= 1'b0;
		end else begin
			rstnMeta_r <= 1'b1;
			rstnSync_r <= rstnMeta_r;
		end
	end

	// Sequencer state
	rst_state_type     state_r, state_nxt;
	logic [7:0]        holdCnt_r, holdCnt_nxt;
	logic              sysRstN_r, sysRstN_nxt;
	logic [DATA_W-1:0] srcReg_r, srcReg_nxt;
	flash_fault_type   cause_r, cause_nxt;

	// Watchdog state
	logic              wdtEn_r, wdtEn_nxt;
	logic [3:0]        preCnt_r, preCnt_nxt;
	logic [DATA_W-1:0] wdtCnt_r, wdtCnt_nxt;
	logic [DATA_W-1:0] wdtLim_r, wdtLim_nxt;

	// Register port and interrupt state
	logic [EV_W-1:0]   irqSt_r, irqSt_nxt;
	logic [EV_W-1:0]   irqMsk_r, irqMsk_nxt;
	logic [DATA_W-1:0] rdData_r, rdData_nxt;
	logic              irq_r, irq_nxt;
	logic              pinOut_r, pinOe_r;

	logic              running;
	logic              flashHit;
	logic              swHit;
	logic              wdtTick;
	logic              wdtHit;
	logic [EV_W-1:0]   events;

	assign running  = (state_r == ST_RUN);
	// Faults are ignored while the reset is already held; the chip is being reset anyway
	assign flashHit = running && (|flashFault); // R4 R5 R6 R7 R8
	assign swHit    = running && regReq.wr && (regReq.addr == OFF_SRC)
	                  && regReq.wrData[BIT_SW_FORCE]; // R10
	assign wdtTick  = (preCnt_r == WDT_DIV - 4'h1); // R1
	assign wdtHit   = running && wdtEn_r && wdtTick && (wdtCnt_r == wdtLim_r); // R2

	always_comb begin
		events           = ZERO_EV;
		events[EV_SW]    = swHit;
		events[EV_WDT]   = wdtHit;
		events[EV_FLASH] = flashHit;
	end

	// Reset sequencer
	always_comb begin
		state_nxt   = state_r;
		holdCnt_nxt = holdCnt_r;
		sysRstN_nxt = sysRstN_r;
		srcReg_nxt  = srcReg_r;
		cause_nxt   = cause_r;
		unique case (state_r)
			ST_RUN: begin
				sysRstN_nxt = 1'b1;
				if (|events) begin
					state_nxt   = ST_HOLD;
					holdCnt_nxt = HOLD_LOAD;
					sysRstN_nxt = 1'b0; // R12
					// Flags name the latest cause; coinciding causes all show
					srcReg_nxt                = ZERO_BYTE;
					srcReg_nxt[BIT_SW_FORCE]  = swHit; // R11
					srcReg_nxt[BIT_WDT_FLAG]  = wdtHit; // R2
					srcReg_nxt[BIT_FLASH_ERR] = flashHit; // R9
					if (flashHit) begin
						cause_nxt = flashFault;
					end
				end
			end
			ST_HOLD: begin
				if (holdCnt_r == 8'h00) begin
					state_nxt   = ST_RUN;
					sysRstN_nxt = 1'b1; // R12
				end else begin
					holdCnt_nxt = holdCnt_r - 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstnSync_r) begin
		if (!rstnSync_r) begin
			state_r   <= ST_RUN;
			holdCnt_r <= 8'h00;
			sysRstN_r <= 1'b0;
			srcReg_r  <= ZERO_BYTE;
			cause_r   <= '0;
		end else begin
			state_r   <= state_nxt;
			holdCnt_r <= holdCnt_nxt;
			sysRstN_r <= sysRstN_nxt;
			srcReg_r  <= srcReg_nxt;
			cause_r   <= cause_nxt;
		end
	end

	// Watchdog: restarted by any internal reset as well as by rstn
	always_comb begin
		wdtEn_nxt  = wdtEn_r;
		preCnt_nxt = wdtTick ? 4'h0 : preCnt_r + 4'h1;
		wdtCnt_nxt = wdtCnt_r;
		wdtLim_nxt = wdtLim_r;
		if (!running) begin
			wdtEn_nxt  = 1'b1; // R1
			preCnt_nxt = 4'h0;
			wdtCnt_nxt = ZERO_BYTE;
			wdtLim_nxt = LIMIT_RESET;
		end else begin
			if (wdtEn_r && wdtTick) begin
				wdtCnt_nxt = wdtCnt_r + 8'h01;
			end
			if (regReq.wr && regReq.addr == OFF_WDT_CTL) begin
				wdtEn_nxt = regReq.wrData[BIT_WDT_EN];
				if (regReq.wrData[BIT_WDT_KICK]) begin
					wdtCnt_nxt = ZERO_BYTE;
				end
			end
			if (regReq.wr && regReq.addr == OFF_WDT_LIM) begin
				wdtLim_nxt = regReq.wrData;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstnSync_r) begin
		if (!rstnSync_r) begin
			wdtEn_r  <= 1'b1;
			preCnt_r <= 4'h0;
			wdtCnt_r <= ZERO_BYTE;
			wdtLim_r <= LIMIT_RESET;
		end else begin
			wdtEn_r  <= wdtEn_nxt;
			preCnt_r <= preCnt_nxt;
			wdtCnt_r <= wdtCnt_nxt;
			wdtLim_r <= wdtLim_nxt;
		end
	end

	// Register reads and interrupt status; an event beats a read-clear
	always_comb begin
		rdData_nxt = ZERO_BYTE;
		irqSt_nxt  = irqSt_r;
		irqMsk_nxt = irqMsk_r;
		if (regReq.rd) begin
			unique case (regReq.addr)
				OFF_SRC:     rdData_nxt = srcReg_r;
				OFF_WDT_CTL: rdData_nxt = {7'h00, wdtEn_r};
				OFF_WDT_LIM: rdData_nxt = wdtLim_r;
				OFF_CAUSE:   rdData_nxt = {3'h0, cause_r};
				OFF_IRQ_ST:  rdData_nxt = {5'h00, irqSt_r};
				OFF_IRQ_MSK: rdData_nxt = {5'h00, irqMsk_r};
				default:     rdData_nxt = ZERO_BYTE;
			endcase
			if (regReq.addr == OFF_IRQ_ST) begin
				irqSt_nxt = ZERO_EV;
			end
		end
		if (regReq.wr && regReq.addr == OFF_IRQ_MSK) begin
			irqMsk_nxt = regReq.wrData[EV_W-1:0];
		end
		irqSt_nxt = irqSt_nxt | events;
		irq_nxt   = |(irqSt_nxt & irqMsk_nxt);
	end

	always_ff @(posedge mclk or negedge rstnSync_r) begin
		if (!rstnSync_r) begin
			rdData_r <= ZERO_BYTE;
			irqSt_r  <= ZERO_EV;
			irqMsk_r <= ZERO_EV;
			irq_r    <= 1'b0;
		end else begin
			rdData_r <= rdData_nxt;
			irqSt_r  <= irqSt_nxt;
			irqMsk_r <= irqMsk_nxt;
			irq_r    <= irq_nxt;
		end
	end

	// The external pin stays undriven; internal causes never reach it
	always_ff @(posedge mclk or negedge rstnSync_r) begin
		if (!rstnSync_r) begin
			pinOut_r <= 1'b0;
			pinOe_r  <= 1'b0;
		end else begin
			pinOut_r <= 1'b0; // R3
			pinOe_r  <= 1'b0; // R3
		end
	end

	assign regRdData = rdData_r;
	assign sysResetN = sysRstN_r;
	assign rstPinOut = pinOut_r;
	assign rstPinOe  = pinOe_r;
	assign irq       = irq_r;

	// Helper for the hold check: length of the current low stretch of sysResetN
	logic [7:0]        lowRun_r, lowRun_nxt;

	always_comb begin
		lowRun_nxt = sysResetN ? 8'h00 : lowRun_r + 8'h01;
	end

	always_ff @(posedge mclk or negedge rstnSync_r) begin
		if (!rstnSync_r) begin
			lowRun_r <= 8'h00;
		end else begin
			lowRun_r <= lowRun_nxt;
		end
	end

	sw_reset_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R10
		swHit |=> !sysResetN && srcReg_r[BIT_SW_FORCE])
		else $error("software reset not taken");

	sw_flag_keep_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R11
		(state_r == ST_HOLD && $past(swHit)) |-> ##[0:256] (running && srcReg_r[BIT_SW_FORCE]))
		else $error("software flag lost across reset");

	wdt_reset_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R2
		wdtHit |=> !sysResetN && srcReg_r[BIT_WDT_FLAG])
		else $error("watchdog expiry did not reset");

	flash_reset_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R9
		(running && |flashFault) |=> !sysResetN && srcReg_r[BIT_FLASH_ERR])
		else $error("flash fault did not reset");

	wdt_restart_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R1
		($rose(sysResetN) && $past(state_r) == ST_HOLD)
		|-> wdtEn_r && wdtCnt_r == ZERO_BYTE && preCnt_r == 4'h0)
		else $error("watchdog not restarted after reset");

	wdt_wrap_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R1
		(running && wdtTick) |=> preCnt_r == 4'h0)
		else $error("watchdog prescaler did not wrap");

	wdt_divide_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R1
		(running && wdtTick) ##1 running [*8] ##1 running [*3] |=> wdtTick)
		else $error("watchdog prescaler not divide by twelve");

	wdt_count_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R1
		(running && wdtEn_r && wdtTick && wdtCnt_r != wdtLim_r
		&& !(regReq.wr && regReq.addr == OFF_WDT_CTL)) |=> wdtCnt_r == $past(wdtCnt_r) + 8'h01)
		else $error("watchdog count did not advance");

	wdt_stopped_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R1
		(running && !wdtEn_r && !(regReq.wr && regReq.addr == OFF_WDT_CTL)) |=> $stable(wdtCnt_r))
		else $error("disabled watchdog counted");

	wdt_enable_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R1
		!running |=> wdtEn_r && wdtLim_r == LIMIT_RESET)
		else $error("watchdog settings not restored");

	pin_quiet_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R3
		!rstPinOe && !rstPinOut)
		else $error("reset pin driven");

	hold_len_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R12
		($rose(sysResetN) && $past(state_r) == ST_HOLD) |-> lowRun_r == HOLD_CYCLES)
		else $error("internal reset length wrong");

	no_spurious_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R12
		(running && !(|events) && sysResetN) |=> sysResetN)
		else $error("internal reset without a cause");

	src_keep_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R12
		!(running && |events) |=> $stable(srcReg_r))
		else $error("source flags changed without a reset");

	flash_cause_a: assert property (@(posedge mclk) disable iff (!rstnSync_r)
		(running && |flashFault) |=> cause_r == $past(flashFault))
		else $error("flash cause not captured");

	irq_level_a: assert property (@(posedge mclk) disable iff (!rstnSync_r)
		(|(irqSt_r & irqMsk_r)) |-> irq)
		else $error("masked status not on interrupt");

	irq_set_a: assert property (@(posedge mclk) disable iff (!rstnSync_r)
		(|events) |=> (irqSt_r & $past(events)) == $past(events))
		else $error("event not recorded in status");

	irq_clear_a: assert property (@(posedge mclk) disable iff (!rstnSync_r)
		(regReq.rd && regReq.addr == OFF_IRQ_ST && !(|events)) |=> irqSt_r == ZERO_EV)
		else $error("status not cleared by read");

	rd_idle_a: assert property (@(posedge mclk) disable iff (!rstnSync_r)
		!regReq.rd |=> regRdData == ZERO_BYTE)
		else $error("read data held too long");

	rd_source_a: assert property (@(posedge mclk) disable iff (!rstnSync_r) // R11
		(regReq.rd && regReq.addr == OFF_SRC) |=> regRdData == $past(srcReg_r))
		else $error("source register read wrong");

endmodule

/* File: tb/flash_fault_model.sv */
// Stand-in for the flash access logic: turns a one-cycle request into a fault report.
// Assumes the bench pulses faultReq for one cycle at a time on mclk.
`timescale 1ns/1ps
module flash_fault_model
	import internal_reset_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rstn,
	input  wire logic [FAULT_W-1:0] faultReq,
	output flash_fault_type         flashFault
);
	// Report lasts one cycle, then drops, so a stuck fault never hides a missed reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flashFault <= '0;
		end else begin
			flashFault <= flash_fault_type'(faultReq);
		end
	end
endmodule

/* File: tb/test_internal_reset_sources.sv */
// Self-checking bench for the internal reset source block.
// Assumes one 50 MHz clock and the flash fault model on the fault inputs.
`timescale 1ns/1ps
module test_internal_reset_sources
	import internal_reset_pkg::*;
;
	localparam int HOLD = 3;
	logic              mclk;
	logic              rstn;
	logic              sysResetN;
	logic              rstPinOut;
	logic              rstPinOe;
	logic              irq;
	reg_req_type       regReq;
	logic [DATA_W-1:0] regRdData;
	logic [FAULT_W-1:0] faultReq;
	flash_fault_type   flashFault;
	int                fails = 0;
	int                compares = 0;
	int                cycles = 0;
	int                n;

	internal_reset_sources #(.HOLD_CYCLES(HOLD), .LIMIT_RESET(8'h07)) dut (
		.mclk(mclk), .rstn(rstn), .regReq(regReq), .regRdData(regRdData),
		.flashFault(flashFault), .sysResetN(sysResetN), .rstPinOut(rstPinOut),
		.rstPinOe(rstPinOe), .irq(irq));
	flash_fault_model model (.mclk(mclk), .rstn(rstn), .faultReq(faultReq),
		.flashFault(flashFault));

	task automatic conclude();
		if (fails == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		regReq.wr <= 1'b0;
	endtask
	task automatic rdCheck(input logic [3:0] a, input logic [7:0] exp, input string msg);
		@(posedge mclk);
		regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		regReq.rd <= 1'b0;
		#1 check(regRdData, exp, msg);
	endtask
	// Counts cycles of the internal reset; capped so a stuck reset cannot hang
	task automatic holdLen(output int len);
		len = 0;
		while (sysResetN === 1'b0 && len < 300) begin
			len++;
			@(posedge mclk);
			#1;
		end
	endtask
	task automatic fire(input logic [FAULT_W-1:0] bits);
		@(posedge mclk);
		faultReq <= bits;
		@(posedge mclk);
		faultReq <= '0;
		@(posedge mclk);
		#1;
	endtask

	task automatic tReset();
		check(8'(sysResetN), 8'h01, "running after reset");
		check(8'({rstPinOe, rstPinOut}), 8'h00, "pin driven");
		rdCheck(OFF_WDT_CTL, 8'h01, "watchdog off");
		rdCheck(4'hF, 8'h00, "unmapped read");
	endtask
	task automatic tFaults();
		wrReg(OFF_IRQ_MSK, 8'h07);
		for (int i = 0; i < FAULT_W; i++) begin
			fire(FAULT_W'(1) << i);
			check(8'(sysResetN), 8'h00, "no fault reset");
			holdLen(n);
			check(8'(n), 8'(HOLD), "hold length");
			check(8'({rstPinOe, rstPinOut}), 8'h00, "pin driven");
			check(8'(irq), 8'h01, "irq low");
			rdCheck(OFF_SRC, 8'h40, "flash flag");
			rdCheck(OFF_CAUSE, 8'(1 << i), "fault cause");
			rdCheck(OFF_WDT_CTL, 8'h01, "watchdog off");
			rdCheck(OFF_IRQ_ST, 8'h04, "irq status");
			repeat (2) @(posedge mclk);
			#1 check(8'(irq), 8'h00, "irq stuck");
		end
	endtask
	task automatic tSoftware();
		wrReg(OFF_IRQ_MSK, 8'h00);
		wrReg(OFF_SRC, 8'h00);
		#1 check(8'(sysResetN), 8'h01, "reset on zero write");
		wrReg(OFF_SRC, 8'h10);
		#1 check(8'(sysResetN), 8'h00, "no software reset");
		holdLen(n);
		check(8'(n), 8'(HOLD), "hold length");
		check(8'({rstPinOe, rstPinOut}), 8'h00, "pin driven");
		check(8'(irq), 8'h00, "masked irq");
		rdCheck(OFF_SRC, 8'h10, "software flag");
		rdCheck(OFF_IRQ_ST, 8'h01, "irq status");
	endtask
	// Limit 7 gives eight ticks of twelve cycles; prescaler phase allows one tick of slack
	task automatic tWatchdog();
		wrReg(OFF_WDT_CTL, 8'h03);
		n = 0;
		while (sysResetN === 1'b1 && n < 500) begin
			@(posedge mclk);
			#1 n++;
		end
		check(8'(n >= 84 && n <= 110), 8'h01, "expiry time");
		holdLen(n);
		check(8'(n), 8'(HOLD), "hold length");
		rdCheck(OFF_SRC, 8'h20, "watchdog flag");
		wrReg(OFF_WDT_CTL, 8'h00);
		repeat (300) @(posedge mclk);
		#1 check(8'(sysResetN), 8'h01, "disabled watchdog fired");
	endtask
	// Pin reset in mid-run: flags clear, watchdog and mask back to reset values
	task automatic tRestart();
		wrReg(OFF_WDT_LIM, 8'h05);
		wrReg(OFF_IRQ_MSK, 8'h05);
		rdCheck(OFF_WDT_LIM, 8'h05, "limit write");
		rdCheck(OFF_IRQ_MSK, 8'h05, "mask write");
		@(posedge mclk);
		#1 check(regRdData, 8'h00, "read data held");
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 check(8'(sysResetN), 8'h01, "running after pin reset");
		rdCheck(OFF_SRC, 8'h00, "flags after pin reset");
		rdCheck(OFF_WDT_CTL, 8'h01, "watchdog off after pin reset");
		rdCheck(OFF_WDT_LIM, 8'h07, "limit not restored");
		rdCheck(OFF_IRQ_MSK, 8'h00, "mask not cleared");
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		rstn = 1'b0;
		regReq = '0;
		faultReq = '0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		tReset();
		tFaults();
		tSoftware();
		tWatchdog();
		tRestart();
		conclude();
	end
endmodule
